// ### inc/hp_pkg.sv
// Purpose: Shared constants and carrier types of the hot-plug register bank.
// Assumes: One 10 MHz clock; SMBus pins sampled synchronously.
// Notes:   Bit positions are byte positions within the 8-bit registers.
`default_nettype none
package hp_pkg;

  // Command byte values that select a register.
  localparam logic [7:0] CMD_SLOT_A_CONTROL = 8'h02;
  localparam logic [7:0] CMD_SLOT_B_CONTROL = 8'h03;
  localparam logic [7:0] CMD_SLOT_A_STATUS  = 8'h04;
  localparam logic [7:0] CMD_SLOT_B_STATUS  = 8'h05;
  localparam logic [7:0] CMD_SHARED_STATUS  = 8'h06;

  // Values after power-up.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [3:0] SHARED_RESET  = 4'h0;

  // Control register fields.
  localparam int CTRL_AUX_ENABLE_BIT  = 0;
  localparam int CTRL_MAIN_ENABLE_BIT = 1;
  localparam int CTRL_FORCE_GATE_BIT  = 2;

  // Status register fields.
  localparam int STAT_3V3_OC_BIT = 0;
  localparam int STAT_12V_OC_BIT = 2;
  localparam int STAT_AUX_OC_BIT = 4;

  // Shared status register fields.
  localparam int SHARED_INTMSK_BIT = 3;

  // Fixed upper part of the 7-bit bus address; straps give the low three.
  localparam logic [3:0] DEV_ADDR_HIGH = 4'h8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Pins and analog detections of one slot.
  typedef struct packed {
    logic power_on_input;
    logic aux_request_input;
    logic force_input_n;
    logic aux_power_good;
    logic main_power_good;
    logic aux_overcurrent;
    logic oc_12v;
    logic oc_3v3;
  } slot_in_t;

  // Outputs of one slot; every field comes from a flip-flop.
  typedef struct packed {
    logic main_enable;
    logic aux_enable;
    logic power_good_oe;
    logic fault_oe;
  } slot_out_t;

endpackage : hp_pkg
`default_nettype wire

// ### src/hot_plug_slot_register_bank.sv
// Purpose: SMBus register bank of a dual-slot hot-plug power controller.
// Assumes: SCL and SDA are synchronous to clk and far slower than it.
// Notes:   Supports Write_Byte, Read_Byte and Receive_Byte only.
`timescale 1ns/1ps
`default_nettype none
module hot_plug_slot_register_bank (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             smbus_scl,
  input  wire logic             smbus_sda_in,
  output logic                  smbus_sda_out,
  output logic                  smbus_sda_oe,
  input  wire logic [2:0]       addr_strap,
  input  wire logic [1:0]       gpi,
  input  wire hp_pkg::slot_in_t slot_a_in,
  input  wire hp_pkg::slot_in_t slot_b_in,
  output hp_pkg::slot_out_t     slot_a_drive,
  output hp_pkg::slot_out_t     slot_b_drive,
  output logic                  int_out,
  output logic                  int_oe
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } bus_state_t;

  bus_state_t state_q;
  logic [2:0] dev_addr_q;
  logic       strap_done_q;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shift_q;
  logic [7:0] rd_shift_q;
  logic [3:0] bit_q;
  logic [7:0] cmd_q;
  logic       rw_q;
  logic       mack_q;
  logic       wr_q;
  logic [7:0] wdata_q;
  logic       intmsk_q;
  logic       sda_oe_q;
  logic       int_oe_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       byte_done;
  logic [7:0] rd_data;
  logic [7:0] ctrl_a_rd;
  logic [7:0] ctrl_b_rd;
  logic [7:0] stat_a_rd;
  logic [7:0] stat_b_rd;
  logic [7:0] shared_rd;
  logic       any_flag;

  // Bus edge and condition detection on the sampled lines.
  assign scl_rise  = smbus_scl && !scl_q;
  assign scl_fall  = !smbus_scl && scl_q;
  assign start_det = smbus_scl && scl_q && sda_q && !smbus_sda_in;
  assign stop_det  = smbus_scl && scl_q && !sda_q && smbus_sda_in;
  assign byte_done = scl_fall && (bit_q == hp_pkg::BITS_PER_BYTE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= smbus_scl;
      sda_q <= smbus_sda_in;
    end
  end

  // Straps are taken once, at the first edge after reset is released,
  // so later changes on those pins cannot move the device address.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dev_addr_q   <= 3'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      dev_addr_q   <= addr_strap;
      strap_done_q <= 1'b1;
    end
  end

  // Register read multiplexer; unknown commands read as zero.
  assign shared_rd = {2'h0, gpi, intmsk_q, 3'h0};
  always_comb begin
    unique case (cmd_q)
      hp_pkg::CMD_SLOT_A_CONTROL: rd_data = ctrl_a_rd;
      hp_pkg::CMD_SLOT_B_CONTROL: rd_data = ctrl_b_rd;
      hp_pkg::CMD_SLOT_A_STATUS:  rd_data = stat_a_rd;
      hp_pkg::CMD_SLOT_B_STATUS:  rd_data = stat_b_rd;
      hp_pkg::CMD_SHARED_STATUS:  rd_data = shared_rd;
      default:                    rd_data = 8'h00;
    endcase
  end

  // Bit counter and receive shifter sample SDA on rising SCL.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= 8'h00;
      bit_q   <= 4'h0;
      mack_q  <= 1'b0;
    end else if (start_det || (scl_fall && bit_q ==
                 hp_pkg::BITS_PER_BYTE)) begin
      bit_q <= 4'h0;
    end else if (scl_rise) begin
      // Ack clocks are not data bits, so they must not move the count.
      if (state_q == ST_RDATA_ACK) begin
        mack_q <= !smbus_sda_in;
      end else if (state_q != ST_ADDR_ACK && state_q != ST_CMD_ACK &&
                   state_q != ST_WDATA_ACK) begin
        shift_q <= {shift_q[6:0], smbus_sda_in};
        bit_q   <= bit_q + 4'h1;
      end
    end
  end

  // Protocol sequencer; a repeated start re-enters address phase,
  // which is how Read_Byte follows its command byte.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= ST_IDLE;
      sda_oe_q   <= 1'b0;
      rw_q       <= 1'b0;
      rd_shift_q <= 8'h00;
    end else if (start_det) begin
      state_q  <= ST_ADDR;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (shift_q[7:1] == {hp_pkg::DEV_ADDR_HIGH, dev_addr_q}) begin
              state_q  <= ST_ADDR_ACK;
              sda_oe_q <= 1'b1;
              rw_q     <= shift_q[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          // Read without command byte reuses the latched command.
          if (rw_q) begin
            state_q    <= ST_RDATA;
            sda_oe_q   <= !rd_data[7];
            rd_shift_q <= {rd_data[6:0], 1'b0};
          end else begin
            state_q  <= ST_CMD;
            sda_oe_q <= 1'b0;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            state_q  <= ST_CMD_ACK;
            sda_oe_q <= 1'b1;
          end
        end
        ST_CMD_ACK: begin
          state_q  <= ST_WDATA;
          sda_oe_q <= 1'b0;
        end
        ST_WDATA: begin
          if (byte_done) begin
            state_q  <= ST_WDATA_ACK;
            sda_oe_q <= 1'b1;
          end
        end
        ST_WDATA_ACK: begin
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
        ST_RDATA: begin
          if (byte_done) begin
            state_q  <= ST_RDATA_ACK;
            sda_oe_q <= 1'b0;
          end else begin
            sda_oe_q   <= !rd_shift_q[7];
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          // A master ack asks for the same register once more.
          if (mack_q) begin
            state_q    <= ST_RDATA;
            sda_oe_q   <= !rd_data[7];
            rd_shift_q <= {rd_data[6:0], 1'b0};
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Command latch and one-cycle write strobe with its data byte.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q   <= 8'h00;
      wr_q    <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (state_q == ST_CMD && byte_done) begin
        cmd_q <= shift_q;
      end
      if (state_q == ST_WDATA && byte_done) begin
        wr_q    <= 1'b1;
        wdata_q <= shift_q;
      end
    end
  end

  // Shared status: only the interrupt mask is writable here.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intmsk_q <= hp_pkg::SHARED_RESET[0];
    end else if (wr_q && cmd_q == hp_pkg::CMD_SHARED_STATUS) begin
      intmsk_q <= wdata_q[hp_pkg::SHARED_INTMSK_BIT];
    end
  end

  // Interrupt pulls low while any overcurrent flag is set and unmasked;
  // clearing the flags releases it on the following edge.
  assign any_flag = |{stat_a_rd[4], stat_a_rd[2], stat_a_rd[0],
                      stat_b_rd[4], stat_b_rd[2], stat_b_rd[0]};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_oe_q <= 1'b0;
    end else begin
      int_oe_q <= any_flag && !intmsk_q;
    end
  end

  // Both slots share one layout; each sees only its own write strobes.
  hp_slot u_slot_a (
    .clk     (clk),
    .reset   (reset),
    .pins    (slot_a_in),
    .ctrl_wr (wr_q && cmd_q == hp_pkg::CMD_SLOT_A_CONTROL),
    .stat_wr (wr_q && cmd_q == hp_pkg::CMD_SLOT_A_STATUS),
    .wdata   (wdata_q),
    .ctrl_rd (ctrl_a_rd),
    .stat_rd (stat_a_rd),
    .drive   (slot_a_drive)
  );

  hp_slot u_slot_b (
    .clk     (clk),
    .reset   (reset),
    .pins    (slot_b_in),
    .ctrl_wr (wr_q && cmd_q == hp_pkg::CMD_SLOT_B_CONTROL),
    .stat_wr (wr_q && cmd_q == hp_pkg::CMD_SLOT_B_STATUS),
    .wdata   (wdata_q),
    .ctrl_rd (ctrl_b_rd),
    .stat_rd (stat_b_rd),
    .drive   (slot_b_drive)
  );

  // SDA and INT only ever pull low, so their data lines are held at 0.
  assign smbus_sda_out = 1'b0;
  assign smbus_sda_oe  = sda_oe_q;
  assign int_out       = 1'b0;
  assign int_oe        = int_oe_q;

  sequence addr_match;
    state_q == ST_ADDR && byte_done &&
      shift_q[7:1] == {hp_pkg::DEV_ADDR_HIGH, dev_addr_q};
  endsequence

  sequence data_byte_in;
    state_q == ST_WDATA && byte_done && !start_det && !stop_det;
  endsequence

  chk_addr_ack: assert property (@(posedge clk) disable iff (reset)
    addr_match and (!start_det && !stop_det) |=> smbus_sda_oe)
    else $error("Own address not acknowledged.");
  chk_write_strobe: assert property (@(posedge clk) disable iff (reset)
    data_byte_in |=> wr_q && wdata_q == $past(shift_q))
    else $error("Data byte did not produce a write.");
  chk_rsvd_cmd: assert property (@(posedge clk) disable iff (reset)
    cmd_q > hp_pkg::CMD_SHARED_STATUS |-> rd_data == 8'h00)
    else $error("Reserved command returned data.");
  chk_int_clear: assert property (@(posedge clk) disable iff (reset)
    !any_flag ##1 !any_flag |-> !int_oe)
    else $error("Interrupt held with no flag set.");
  chk_power_up: assert property (@(posedge clk)
    $fell(reset) |-> ctrl_a_rd[2:0] == 3'h0 && !slot_a_drive.main_enable)
    else $error("Slot not off after power-up.");

  // Byte framing, address capture, read launch and interrupt masking.
  chk_ack_count: assert property (@(posedge clk) disable iff (reset)
    scl_rise && (state_q == ST_ADDR_ACK || state_q == ST_CMD_ACK ||
      state_q == ST_WDATA_ACK) |=> bit_q == 4'h0)
    else $error("Ack clock counted as a data bit.");
  chk_addr_held: assert property (@(posedge clk) disable iff (reset)
    strap_done_q |=> $stable(dev_addr_q))
    else $error("Bus address moved after it was taken.");
  chk_read_bit: assert property (@(posedge clk) disable iff (reset)
    scl_fall && state_q == ST_ADDR_ACK && rw_q |=>
      smbus_sda_oe == !$past(rd_data[7]))
    else $error("First read bit does not match the register.");
  chk_int_mask: assert property (@(posedge clk) disable iff (reset)
    intmsk_q |=> !int_oe)
    else $error("Interrupt driven while masked.");

endmodule : hot_plug_slot_register_bank
`default_nettype wire

// ### src/hp_slot.sv
// Purpose: Control and status registers plus pin logic of one slot.
// Assumes: Inputs are synchronous to clk.
// Notes:   Instantiated once per slot by the register bank.
`timescale 1ns/1ps
`default_nettype none
module hp_slot (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire hp_pkg::slot_in_t pins,
  input  wire logic             ctrl_wr,
  input  wire logic             stat_wr,
  input  wire logic [7:0]       wdata,
  output logic      [7:0]       ctrl_rd,
  output logic      [7:0]       stat_rd,
  output hp_pkg::slot_out_t     drive
);

  logic [2:0] ctrl_q;
  logic [2:0] flag_q;
  logic       main_on_q;
  logic       aux_on_q;
  logic       main_trip_q;
  logic       aux_trip_q;
  logic       fault_main_q;
  logic       fault_aux_q;
  logic       pg_oe_q;
  logic       fault_oe_q;
  logic       force_eff;
  logic       main_oc;
  logic       fault_bit;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // Force acts on the switches and power good only while the pin is low and the gate bit allows it; fault blanking follows the pin alone.
  assign force_eff = !pins.force_input_n &&
                     !ctrl_q[hp_pkg::CTRL_FORCE_GATE_BIT];
  assign main_oc   = pins.oc_12v | pins.oc_3v3;
  assign fault_bit = fault_main_q | fault_aux_q;

  // Writable enables and force gate; power-up leaves every output off.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= hp_pkg::CONTROL_RESET[2:0];
    end else if (ctrl_wr) begin
      ctrl_q <= wdata[2:0];
    end
  end

  // Supply switches; a trip holds off until the request is dropped.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_trip_q <= 1'b0;
      aux_trip_q  <= 1'b0;
      main_on_q   <= 1'b0;
      aux_on_q    <= 1'b0;
    end else begin
      if (main_on_q && main_oc && !force_eff) begin
        main_trip_q <= 1'b1;
      end else if (!(ctrl_q[1] || pins.power_on_input)) begin
        main_trip_q <= 1'b0;
      end
      if (aux_on_q && pins.aux_overcurrent && !force_eff) begin
        aux_trip_q <= 1'b1;
      end else if (!(ctrl_q[0] || pins.aux_request_input)) begin
        aux_trip_q <= 1'b0;
      end
      // Forcing disables protection, so it overrides any trip.
      main_on_q <= force_eff || ((ctrl_q[1] || pins.power_on_input) &&
                   !main_trip_q && !main_oc);
      aux_on_q  <= force_eff || ((ctrl_q[0] || pins.aux_request_input) &&
                   !aux_trip_q && !pins.aux_overcurrent);
    end
  end

  // Sticky overcurrent flags; a new event beats a write-one clear.
  assign flag_set = {pins.aux_overcurrent & aux_on_q,
                     pins.oc_12v & main_on_q,
                     pins.oc_3v3 & main_on_q};
  assign flag_clr = stat_wr ? {wdata[hp_pkg::STAT_AUX_OC_BIT],
                               wdata[hp_pkg::STAT_12V_OC_BIT],
                               wdata[hp_pkg::STAT_3V3_OC_BIT]} : 3'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_q <= hp_pkg::STATUS_RESET[2:0];
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);
    end
  end

  // Fault latches exist only under pin control and clear as the
  // matching request input goes low; register access never touches them.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_main_q <= 1'b0;
      fault_aux_q  <= 1'b0;
    end else begin
      if (!pins.power_on_input) begin
        fault_main_q <= 1'b0;
      end else if (main_oc && main_on_q) begin
        fault_main_q <= 1'b1;
      end
      if (!pins.aux_request_input) begin
        fault_aux_q <= 1'b0;
      end else if (pins.aux_overcurrent && aux_on_q) begin
        fault_aux_q <= 1'b1;
      end
    end
  end

  // Open-drain pins: power good drives while good and not forced.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pg_oe_q    <= 1'b0;
      fault_oe_q <= 1'b0;
    end else begin
      pg_oe_q    <= pins.aux_power_good && pins.main_power_good &&
                    !force_eff;
      fault_oe_q <= fault_bit && pins.force_input_n;
    end
  end

  // Readback; power good and fault bits ignore the force pin.
  assign ctrl_rd = {pins.aux_power_good, pins.main_power_good,
                    3'h0, ctrl_q};
  assign stat_rd = {fault_bit, main_on_q, aux_on_q, flag_q[2],
                    1'b0, flag_q[1], 1'b0, flag_q[0]};
  assign drive   = '{main_enable:   main_on_q,
                     aux_enable:    aux_on_q,
                     power_good_oe: pg_oe_q,
                     fault_oe:      fault_oe_q};

  // Three idle cycles: one to clear the latch and one more for the pin flop.
  sequence pin_ctrl_idle;
    (!pins.power_on_input && !pins.aux_request_input)[*3];
  endsequence

  chk_flag_clears: assert property (@(posedge clk) disable iff (reset)
    stat_wr && wdata[2] && !(pins.oc_12v && main_on_q) |=> !flag_q[1])
    else $error("Written one did not clear the 12 V flag.");
  chk_flag_sets: assert property (@(posedge clk) disable iff (reset)
    pins.aux_overcurrent && aux_on_q |=> stat_rd[4] ##1 stat_rd[4] || $past(stat_wr))
    else $error("Aux overcurrent flag not set.");
  chk_force_fault: assert property (@(posedge clk) disable iff (reset)
    !pins.force_input_n |=> !drive.fault_oe)
    else $error("Fault pin driven while forced.");
  chk_pg_and: assert property (@(posedge clk) disable iff (reset)
    !force_eff |=> drive.power_good_oe ==
      ($past(pins.aux_power_good) && $past(pins.main_power_good)))
    else $error("Power good pin is not the AND of its bits.");
  chk_pg_forced: assert property (@(posedge clk) disable iff (reset)
    force_eff |=> !drive.power_good_oe)
    else $error("Power good pin driven while forced.");
  chk_smi_fault: assert property (@(posedge clk) disable iff (reset)
    pin_ctrl_idle |-> !stat_rd[7] && !drive.fault_oe ##1 !stat_rd[7])
    else $error("Fault active under bus control.");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
    ctrl_rd[5:3] == 3'h0 && stat_rd[3] == 1'b0 && stat_rd[1] == 1'b0)
    else $error("Reserved bit reads non-zero.");

endmodule : hp_slot
`default_nettype wire

// ### verif/smbus_host.sv
// Purpose: SMBus host model issuing Write_Byte and Read_Byte cycles.
// Assumes: Lines change at falling clk edges, four clocks apart.
// Notes:   SDA is open drain; the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module smbus_host (
  input  wire logic       clk,
  input  wire logic       sda,
  input  wire logic [6:0] addr,
  output logic            scl,
  output logic            sda_low,
  output int              nacks
);
  // Idle lines are high; a missing acknowledge is counted, not fatal.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nacks = 0;
  end
  task automatic w4();
    repeat (4) @(negedge clk);
  endtask : w4
  // Data moves only while SCL is low, so no bit looks like a start or stop.
  task automatic put(input logic b);
    sda_low = !b;
    w4();
    scl = 1'b1;
    w4();
    scl = 1'b0;
    w4();
  endtask : put
  task automatic get(output logic b);
    sda_low = 1'b0;
    w4();
    scl = 1'b1;
    w4();
    b = sda;
    scl = 1'b0;
    w4();
  endtask : get
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    if (a) nacks++;
  endtask : send
  // Used for both the first start and the repeated start.
  task automatic start();
    sda_low = 1'b0;
    w4();
    scl = 1'b1;
    w4();
    sda_low = 1'b1;
    w4();
    scl = 1'b0;
    w4();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    w4();
    scl = 1'b1;
    w4();
    sda_low = 1'b0;
    w4();
  endtask : stop
  task automatic write_byte(input logic [7:0] cmd, input logic [7:0] d);
    start();
    send({addr, 1'b0});
    send(cmd);
    send(d);
    stop();
  endtask : write_byte
  task automatic read_byte(input logic [7:0] cmd, output logic [7:0] d);
    logic b;
    start();
    send({addr, 1'b0});
    send(cmd);
    start();
    send({addr, 1'b1});
    for (int i = 0; i < 8; i++) begin
      get(b);
      d = {d[6:0], b};
    end
    put(1'b1);
    stop();
  endtask : read_byte
endmodule : smbus_host
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench of the hot-plug register bank.
// Assumes: Inputs change on falling clk edges; 100 ns clock.
// Notes:   Register rows first, then fault, force and reset cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] val;
  } row_t;
  logic              clk = 1'b0;
  logic              reset;
  logic              scl;
  logic              sda_low;
  logic              sda_oe;
  logic              sda;
  logic [1:0]        gpi;
  logic [7:0]        rd;
  hp_pkg::slot_in_t  pa;
  hp_pkg::slot_in_t  pb;
  hp_pkg::slot_out_t da;
  hp_pkg::slot_out_t db;
  logic              int_oe;
  int                nacks;
  int                n_errors = 0;
  int                checked = 0;
  localparam logic [2:0] STRAP = 3'h5;
  localparam row_t ROWS [18] = '{
    '{1'b0, 8'h02, 8'h00},
    '{1'b0, 8'h04, 8'h00},
    '{1'b0, 8'h03, 8'h00},
    '{1'b0, 8'h05, 8'h00},
    '{1'b0, 8'h06, 8'h20},
    '{1'b1, 8'h06, 8'h08},
    '{1'b0, 8'h06, 8'h28},
    '{1'b1, 8'h06, 8'h00},
    '{1'b1, 8'h02, 8'hff},
    '{1'b0, 8'h02, 8'h07},
    '{1'b0, 8'h04, 8'h60},
    '{1'b1, 8'h03, 8'h02},
    '{1'b0, 8'h05, 8'h40},
    '{1'b1, 8'h07, 8'h55},
    '{1'b0, 8'h07, 8'h00},
    '{1'b1, 8'h02, 8'h00},
    '{1'b1, 8'h03, 8'h00},
    '{1'b0, 8'h04, 8'h00}
  };
  // The wire is pulled up and low whenever either party pulls it.
  assign sda = !(sda_low | sda_oe);
  always #50 clk = ~clk;
  hot_plug_slot_register_bank uut (
    .clk(clk), .reset(reset), .smbus_scl(scl), .smbus_sda_in(sda),
    .smbus_sda_out(), .smbus_sda_oe(sda_oe), .addr_strap(STRAP),
    .gpi(gpi), .slot_a_in(pa), .slot_b_in(pb), .slot_a_drive(da),
    .slot_b_drive(db), .int_out(), .int_oe(int_oe)
  );
  smbus_host host (
    .clk(clk), .sda(sda), .addr({hp_pkg::DEV_ADDR_HIGH, STRAP}),
    .scl(scl), .sda_low(sda_low), .nacks(nacks)
  );
  task automatic end_sim();
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask : cmp1
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] e);
    host.read_byte(cmd, rd);
    cmp8(rd, e);
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle
  // A hang anywhere ends the run as a failure.
  initial begin
    #5000000;
    n_errors++;
    end_sim();
  end
  // Main sequence: rows, bus-controlled faults, pin faults, force, reset.
  initial begin
    pa = '0;
    pa.force_input_n = 1'b1;
    pb = pa;
    gpi = 2'b10;
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    settle();
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) host.write_byte(ROWS[i].cmd, ROWS[i].val);
      else rd_chk(ROWS[i].cmd, ROWS[i].val);
    end
    host.write_byte(8'h02, 8'h03);
    settle();
    {pa.aux_overcurrent, pa.oc_12v, pa.oc_3v3} = 3'b111;
    repeat (2) @(negedge clk);
    {pa.aux_overcurrent, pa.oc_12v, pa.oc_3v3} = 3'b000;
    settle();
    cmp1(int_oe, 1'b1);
    cmp1(da.fault_oe, 1'b0);
    rd_chk(8'h04, 8'h15);
    host.write_byte(8'h04, 8'h00);
    rd_chk(8'h04, 8'h15);
    host.write_byte(8'h04, 8'h15);
    settle();
    cmp1(int_oe, 1'b0);
    rd_chk(8'h04, 8'h00);
    host.write_byte(8'h02, 8'h00);
    {pa.aux_power_good, pa.main_power_good} = 2'b11;
    {pa.power_on_input, pa.aux_request_input} = 2'b11;
    settle();
    cmp1(da.power_good_oe, 1'b1);
    {pa.aux_overcurrent, pa.oc_3v3} = 2'b11;
    repeat (2) @(negedge clk);
    {pa.aux_overcurrent, pa.oc_3v3} = 2'b00;
    settle();
    cmp1(da.fault_oe, 1'b1);
    rd_chk(8'h04, 8'h91);
    host.write_byte(8'h04, 8'h11);
    settle();
    cmp1(da.fault_oe, 1'b1);
    pa.force_input_n = 1'b0;
    settle();
    cmp1(da.fault_oe, 1'b0);
    cmp1(da.power_good_oe, 1'b0);
    rd_chk(8'h02, 8'hc0);
    rd_chk(8'h04, 8'he0);
    host.write_byte(8'h02, 8'h04);
    settle();
    cmp1(da.power_good_oe, 1'b1);
    rd_chk(8'h02, 8'hc4);
    pa.force_input_n = 1'b1;
    pa.power_on_input = 1'b0;
    settle();
    cmp1(da.fault_oe, 1'b1);
    pa.aux_request_input = 1'b0;
    settle();
    cmp1(da.fault_oe, 1'b0);
    cmp8(nacks[7:0], 8'h00);
    host.write_byte(8'h02, 8'h03);
    settle();
    reset = 1'b1;
    settle();
    cmp8({db, da}, 8'h00);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
